// [src/pbm_defines.svh]
// Index map, field positions, reset values and timing of the bank
`ifndef PBM_DEFINES_SVH
`define PBM_DEFINES_SVH

`define PBM_IDX_CTRL        5'h00
`define PBM_IDX_STAT        5'h01
`define PBM_IDX_ID_HIGH     5'h02
`define PBM_IDX_ID_LOW      5'h03
`define PBM_IDX_ADV         5'h04

`define PBM_CTRL_SRST       15
`define PBM_CTRL_LOOP       14
`define PBM_CTRL_SPEED      13
`define PBM_CTRL_ANEN       12
`define PBM_CTRL_PDOWN      11
`define PBM_CTRL_RESTART    9
`define PBM_CTRL_DUPLEX     8
`define PBM_CTRL_COLTEST    7

`define PBM_STAT_ANDONE     5
`define PBM_STAT_RFAULT     4
`define PBM_STAT_ANABLE     3
`define PBM_STAT_LINK       2
`define PBM_STAT_JABBER     1
`define PBM_STAT_EXTCAP     0
`define PBM_STAT_ABIL_RST   5'h0f

`define PBM_ADV_RFAULT      13
`define PBM_ADV_PAUSE_HI    11
`define PBM_ADV_PAUSE_LO    10
`define PBM_ADV_ABIL_HI     8
`define PBM_ADV_ABIL_LO     5
`define PBM_ADV_SEL_HI      4

`define PBM_LOOP_RST        1'h0
`define PBM_SPEED_RST       1'h1
`define PBM_ANEN_RST        1'h1
`define PBM_PDOWN_RST       1'h0
`define PBM_DUPLEX_RST      1'h0
`define PBM_COLTEST_RST     1'h0
`define PBM_ADV_RF_RST      1'h0
`define PBM_ADV_PAUSE_RST   2'h0
`define PBM_ADV_ABIL_RST    4'hf
`define PBM_ADV_SEL_RST     5'h01

`define PBM_CLK_PERIOD_NS   4
`define PBM_SOFT_RST_NS     40

`endif

// [src/pbm_pkg.sv]
// Types shared by the management register bank
package pbm_pkg;
	typedef logic [15:0] pbm_word_t;
	typedef enum logic [1:0] {
		PBM_PAUSE_NONE,
		PBM_PAUSE_SYM,
		PBM_PAUSE_ASYM,
		PBM_PAUSE_BOTH
	} pbm_pause_t;
	typedef enum {PBM_ST_RUN, PBM_ST_SRST} pbm_state_t;
endpackage

// [src/pbm_latch_bit.sv]
// Latching status bit, latch high or latch low, refreshed by a read
`timescale 1ns/1ps
`default_nettype none
module pbm_latch_bit
	import pbm_pkg::*;
#(
	parameter bit LATCH_LOW = 1'b0
)(
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic clear,
	input  wire logic live,
	input  wire logic readStrobe,
	output logic      value
);
	logic held_q;

	// A read reloads the live level, so an event in the read cycle stays
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			held_q <= 1'b0;
		else if (clear)
			held_q <= 1'b0;
		else if (readStrobe)
			held_q <= live;
		else if (LATCH_LOW)
			held_q <= held_q & live;
		else
			held_q <= held_q | live;
	end

	assign value = held_q;
endmodule // pbm_latch_bit
`default_nettype wire

// [src/pbm_regs.sv]
// Basic management register bank of a 10/100 transceiver
`timescale 1ns/1ps
`default_nettype none
`include "pbm_defines.svh"

module pbm_regs
	import pbm_pkg::*;
#(
	parameter logic [15:0] ID_HIGH_RST = 16'h1234, // Arbitrary value
	parameter logic [15:0] ID_LOW_RST  = 16'h5678  // Arbitrary value
)(
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic [4:0] mgmtIndex,
	input  wire logic [15:0] mgmtWrData,
	input  wire logic       mgmtWrite,
	input  wire logic       mgmtRead,
	output logic     [15:0] mgmtRdData,
	output logic            mgmtRdValid,
	input  wire logic       linkUpIn,
	input  wire logic       remoteFaultIn,
	input  wire logic       jabberIn,
	input  wire logic       anDoneIn,
	input  wire logic       anSpeed100In,
	input  wire logic       anDuplexFullIn,
	input  wire logic [1:0] partnerPauseIn,
	output logic            phyResetOut,
	output logic            loopbackEn,
	output logic            speed100,
	output logic            duplexFull,
	output logic            anEnable,
	output logic            anRestart,
	output logic            powerDown,
	output logic            colTestEn,
	output logic     [15:0] advWord,
	output logic            pauseSymEn,
	output logic            pauseAsymEn
);
	localparam int SoftRstCycles =
		(`PBM_SOFT_RST_NS + `PBM_CLK_PERIOD_NS - 1) / `PBM_CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////
	// Access decode
	pbm_state_t state_q;
	logic [7:0] srstCnt_q;
	logic       cfgClear;
	logic       ctrlWr;
	logic       statRead;
	logic       srstReq;

	assign cfgClear = (state_q == PBM_ST_SRST);
	assign ctrlWr   = mgmtWrite && (mgmtIndex == `PBM_IDX_CTRL) && !cfgClear;
	assign statRead = mgmtRead && (mgmtIndex == `PBM_IDX_STAT);
	// A reset request wins; the rest of that write is dropped
	assign srstReq  = ctrlWr && mgmtWrData[`PBM_CTRL_SRST];

	////////////////////////////////////////////////////////////////////////
	// Soft reset sequencer
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_q   <= PBM_ST_RUN;
			srstCnt_q <= 8'h00;
		end
		else
		begin
			case (state_q)
				PBM_ST_RUN:
				begin
					if (srstReq)
					begin
						state_q   <= PBM_ST_SRST;
						srstCnt_q <= 8'(SoftRstCycles - 1);
					end
				end
				PBM_ST_SRST:
				begin
					if (srstCnt_q == 8'h00)
						state_q <= PBM_ST_RUN;
					else
						srstCnt_q <= srstCnt_q - 8'h01;
				end
				default:
					state_q <= PBM_ST_RUN;
			endcase
		end
	end

	assign phyResetOut = cfgClear;

	////////////////////////////////////////////////////////////////////////
	// Control register
	logic loop_q;
	logic speed_q;
	logic anEn_q;
	logic pdown_q;
	logic restart_q;
	logic duplex_q;
	logic colTest_q;

	// Defaults held for the whole reset leave the device in normal mode
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			loop_q    <= `PBM_LOOP_RST;
			speed_q   <= `PBM_SPEED_RST;
			anEn_q    <= `PBM_ANEN_RST;
			pdown_q   <= `PBM_PDOWN_RST;
			duplex_q  <= `PBM_DUPLEX_RST;
			colTest_q <= `PBM_COLTEST_RST;
		end
		else if (cfgClear || srstReq)
		begin
			loop_q    <= `PBM_LOOP_RST;
			speed_q   <= `PBM_SPEED_RST;
			anEn_q    <= `PBM_ANEN_RST;
			pdown_q   <= `PBM_PDOWN_RST;
			duplex_q  <= `PBM_DUPLEX_RST;
			colTest_q <= `PBM_COLTEST_RST;
		end
		else if (ctrlWr)
		begin
			loop_q    <= mgmtWrData[`PBM_CTRL_LOOP];
			speed_q   <= mgmtWrData[`PBM_CTRL_SPEED];
			anEn_q    <= mgmtWrData[`PBM_CTRL_ANEN];
			pdown_q   <= mgmtWrData[`PBM_CTRL_PDOWN];
			duplex_q  <= mgmtWrData[`PBM_CTRL_DUPLEX];
			colTest_q <= mgmtWrData[`PBM_CTRL_COLTEST];
		end
	end

	// Restart is a one-cycle request to the negotiation engine
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			restart_q <= 1'b0;
		else
			restart_q <= ctrlWr && !srstReq
				&& mgmtWrData[`PBM_CTRL_RESTART];
	end

	////////////////////////////////////////////////////////////////////////
	// Operating outputs
	logic effSpeed_q;
	logic effDuplex_q;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			effSpeed_q  <= `PBM_SPEED_RST;
			effDuplex_q <= `PBM_DUPLEX_RST;
		end
		else if (anEn_q)
		begin
			effSpeed_q  <= anSpeed100In;
			effDuplex_q <= anDuplexFullIn;
		end
		else
		begin
			effSpeed_q  <= speed_q;
			effDuplex_q <= duplex_q;
		end
	end

	assign loopbackEn = loop_q;
	assign speed100   = effSpeed_q;
	assign duplexFull = effDuplex_q;
	assign anEnable   = anEn_q;
	assign anRestart  = restart_q;
	assign powerDown  = pdown_q;
	assign colTestEn  = colTest_q;

	////////////////////////////////////////////////////////////////////////
	// Identifier and advertisement registers
	logic [15:0] idHigh_q;
	logic [15:0] idLow_q;
	logic        advRf_q;
	logic [1:0]  advPause_q;
	logic [3:0]  advAbil_q;
	logic [4:0]  advSel_q;
	logic        advWr;

	assign advWr = mgmtWrite && (mgmtIndex == `PBM_IDX_ADV) && !cfgClear;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			idHigh_q <= ID_HIGH_RST;
			idLow_q  <= ID_LOW_RST;
		end
		else if (cfgClear)
		begin
			idHigh_q <= ID_HIGH_RST;
			idLow_q  <= ID_LOW_RST;
		end
		else if (mgmtWrite && (mgmtIndex == `PBM_IDX_ID_HIGH))
			idHigh_q <= mgmtWrData;
		else if (mgmtWrite && (mgmtIndex == `PBM_IDX_ID_LOW))
			idLow_q  <= mgmtWrData;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			advRf_q    <= `PBM_ADV_RF_RST;
			advPause_q <= `PBM_ADV_PAUSE_RST;
			advAbil_q  <= `PBM_ADV_ABIL_RST;
			advSel_q   <= `PBM_ADV_SEL_RST;
		end
		else if (cfgClear)
		begin
			advRf_q    <= `PBM_ADV_RF_RST;
			advPause_q <= `PBM_ADV_PAUSE_RST;
			advAbil_q  <= `PBM_ADV_ABIL_RST;
			advSel_q   <= `PBM_ADV_SEL_RST;
		end
		else if (advWr)
		begin
			advRf_q    <= mgmtWrData[`PBM_ADV_RFAULT];
			advPause_q <= mgmtWrData[`PBM_ADV_PAUSE_HI:`PBM_ADV_PAUSE_LO];
			advAbil_q  <= mgmtWrData[`PBM_ADV_ABIL_HI:`PBM_ADV_ABIL_LO];
			advSel_q   <= mgmtWrData[`PBM_ADV_SEL_HI:0];
		end
	end

	assign advWord = {2'h0, advRf_q, 1'h0, advPause_q, 1'h0,
		advAbil_q, advSel_q};

	////////////////////////////////////////////////////////////////////////
	// Pause resolution at negotiation completion
	logic anDonePrev_q;
	logic pauseSym_q;
	logic pauseAsym_q;
	pbm_pause_t localPause;

	assign localPause = pbm_pause_t'(advPause_q);

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			anDonePrev_q <= 1'b0;
		else
			anDonePrev_q <= anDoneIn;
	end

	// Symmetric is preferred; never both at once
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pauseSym_q  <= 1'b0;
			pauseAsym_q <= 1'b0;
		end
		else if (cfgClear || !anDoneIn)
		begin
			pauseSym_q  <= 1'b0;
			pauseAsym_q <= 1'b0;
		end
		else if (!anDonePrev_q)
		begin
			case (localPause)
				PBM_PAUSE_SYM:
				begin
					pauseSym_q  <= partnerPauseIn[0];
					pauseAsym_q <= 1'b0;
				end
				PBM_PAUSE_ASYM:
				begin
					pauseSym_q  <= 1'b0;
					pauseAsym_q <= partnerPauseIn == 2'h3;
				end
				PBM_PAUSE_BOTH:
				begin
					pauseSym_q  <= partnerPauseIn[0];
					pauseAsym_q <= partnerPauseIn == 2'h2;
				end
				default:
				begin
					pauseSym_q  <= 1'b0;
					pauseAsym_q <= 1'b0;
				end
			endcase
		end
	end

	assign pauseSymEn  = pauseSym_q;
	assign pauseAsymEn = pauseAsym_q;

	////////////////////////////////////////////////////////////////////////
	// Status register
	logic rfSeen;
	logic linkSeen;
	logic jabSeen;

	pbm_latch_bit #(.LATCH_LOW(1'b0)) u_rf_latch (
		.clk_sys    (clk_sys),
		.rst_n      (rst_n),
		.clear      (cfgClear),
		.live       (remoteFaultIn),
		.readStrobe (statRead),
		.value      (rfSeen)
	);

	pbm_latch_bit #(.LATCH_LOW(1'b1)) u_link_latch (
		.clk_sys    (clk_sys),
		.rst_n      (rst_n),
		.clear      (cfgClear),
		.live       (linkUpIn),
		.readStrobe (statRead),
		.value      (linkSeen)
	);

	pbm_latch_bit #(.LATCH_LOW(1'b0)) u_jab_latch (
		.clk_sys    (clk_sys),
		.rst_n      (rst_n),
		.clear      (cfgClear),
		.live       (jabberIn),
		.readStrobe (statRead),
		.value      (jabSeen)
	);

	pbm_word_t statWord;
	pbm_word_t ctrlWord;

	always_comb
	begin
		statWord = 16'h0000;
		statWord[15:11] = `PBM_STAT_ABIL_RST;
		statWord[`PBM_STAT_ANDONE] = anDoneIn && anEn_q;
		statWord[`PBM_STAT_RFAULT] = rfSeen;
		statWord[`PBM_STAT_ANABLE] = 1'b1;
		statWord[`PBM_STAT_LINK]   = linkSeen;
		statWord[`PBM_STAT_JABBER] = jabSeen;
		statWord[`PBM_STAT_EXTCAP] = 1'b1;
	end

	assign ctrlWord = {cfgClear, loop_q, speed_q, anEn_q, pdown_q, 1'h0,
		restart_q, duplex_q, colTest_q, 7'h00};

	////////////////////////////////////////////////////////////////////////
	// Indexed read port
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mgmtRdData  <= 16'h0000;
			mgmtRdValid <= 1'b0;
		end
		else
		begin
			mgmtRdValid <= mgmtRead;
			if (mgmtRead)
			begin
				case (mgmtIndex)
					`PBM_IDX_CTRL:    mgmtRdData <= ctrlWord;
					`PBM_IDX_STAT:    mgmtRdData <= statWord;
					`PBM_IDX_ID_HIGH: mgmtRdData <= idHigh_q;
					`PBM_IDX_ID_LOW:  mgmtRdData <= idLow_q;
					`PBM_IDX_ADV:     mgmtRdData <= advWord;
					default:          mgmtRdData <= 16'h0000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// Length of the current soft reset, for the checks below
	logic [7:0] srstLen_q;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			srstLen_q <= 8'h00;
		else if (phyResetOut)
			srstLen_q <= srstLen_q + 8'h01;
		else
			srstLen_q <= 8'h00;
	end

	sequence s_srst_start;
		srstReq && !cfgClear;
	endsequence

	sequence s_srst_body;
		phyResetOut ##9 (phyResetOut && srstLen_q == 8'(SoftRstCycles - 1))
			##1 !phyResetOut;
	endsequence

	a_srst_self_clear: assert property (
		s_srst_start |=> s_srst_body)
		else $error("soft reset did not self-clear on time");

	a_srst_len_cap: assert property (
		phyResetOut |-> srstLen_q < 8'(SoftRstCycles))
		else $error("soft reset held too long");

	a_srst_normal_mode: assert property (
		$fell(phyResetOut) |-> !loopbackEn && !powerDown && anEnable)
		else $error("not in normal mode after soft reset");

	a_loop_follows: assert property (
		ctrlWr && !srstReq |=> loopbackEn == $past(mgmtWrData[14]))
		else $error("loopback bit did not take written value");

	a_an_overrides: assert property (
		anEn_q && $stable(anEn_q) |=> speed100 == $past(anSpeed100In)
			&& duplexFull == $past(anDuplexFullIn))
		else $error("manual speed or duplex used under autoneg");

	a_manual_speed: assert property (
		!anEn_q |=> speed100 == $past(speed_q))
		else $error("manual speed not applied");

	a_restart_pulse: assert property (
		ctrlWr && !srstReq && mgmtWrData[9] |=> anRestart ##1 !anRestart)
		else $error("restart bit not a self-clearing pulse");

	sequence s_stat_read;
		statRead ##1 mgmtRdValid;
	endsequence

	a_fixed_ability: assert property (
		s_stat_read |-> mgmtRdData[15:11] == 5'h0f && mgmtRdData[3]
			&& mgmtRdData[0])
		else $error("fixed status bits wrong");

	a_jabber_latch: assert property (
		jabberIn && !statRead && !cfgClear ##1 s_stat_read
			|-> mgmtRdData[1])
		else $error("jabber event lost before read");

	a_link_latch_low: assert property (
		!linkUpIn && !statRead ##1 s_stat_read |-> !mgmtRdData[2])
		else $error("link loss not held until read");

	a_rfault_latch: assert property (
		remoteFaultIn && !statRead && !cfgClear ##1 s_stat_read
			|-> mgmtRdData[4])
		else $error("remote fault lost before read");

	a_pause_single: assert property (
		!(pauseSymEn && pauseAsymEn))
		else $error("both pause settings active");
endmodule // pbm_regs
`default_nettype wire

// [sim/pbm_host_model.sv]
// Host MAC side model driving the indexed management port
`timescale 1ns/1ps
`default_nettype none
module pbm_host_model (
	input  wire logic        clk_sys,
	output logic      [4:0]  mgmtIndex,
	output logic      [15:0] mgmtWrData,
	output logic             mgmtWrite,
	output logic             mgmtRead,
	input  wire logic [15:0] mgmtRdData,
	input  wire logic        mgmtRdValid
);
	logic timedOut;

	initial
	begin
		mgmtIndex = 5'h00;
		mgmtWrData = 16'h0000;
		mgmtWrite = 1'b0;
		mgmtRead = 1'b0;
		timedOut = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Indexed access; bus shows inverted junk when idle
	task automatic wr(input logic [4:0] idx, input logic [15:0] d);
		@(posedge clk_sys);
		#1;
		mgmtIndex = idx;
		mgmtWrData = d;
		mgmtWrite = 1'b1;
		@(posedge clk_sys);
		#1;
		mgmtWrite = 1'b0;
		mgmtWrData = ~d;
		mgmtIndex = ~idx;
	endtask

	task automatic rd(input logic [4:0] idx, output logic [15:0] d);
		int i;
		logic got;
		@(posedge clk_sys);
		#1;
		mgmtIndex = idx;
		mgmtRead = 1'b1;
		@(posedge clk_sys);
		#1;
		mgmtRead = 1'b0;
		mgmtIndex = ~idx;
		got = 1'b0;
		d = 16'h0000;
		// Answer stands for the cycle after the read is taken
		for (i = 0; i < 8 && !got; i++)
		begin
			got = (mgmtRdValid === 1'b1);
			d = mgmtRdData;
			if (!got)
			begin
				@(posedge clk_sys);
				#1;
			end
		end
		timedOut = !got;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Control writes: autoneg off before power down, no reset bit
	task automatic ctrl(input logic [15:0] d, output logic [15:0] v);
		v = d[11] ? (d & 16'h6fff) : (d & 16'h7fff);
		if (d[11])
			wr(5'h00, v & 16'h67ff);
		wr(5'h00, v);
	endtask

	task automatic softReset();
		wr(5'h00, 16'h8000);
	endtask
endmodule // pbm_host_model
`default_nettype wire

// [sim/pbm_regs_test.sv]
// Self-checking bench of the management register bank
`timescale 1ns/1ps
`default_nettype none
module pbm_regs_test
	import pbm_pkg::*;
;
	localparam logic [15:0] IDH = 16'h2c4d; // Arbitrary value
	localparam logic [15:0] IDL = 16'h9a31; // Arbitrary value
	logic        clk_sys, rst_n, mgmtWrite, mgmtRead, mgmtRdValid;
	logic [4:0]  mgmtIndex;
	logic [15:0] mgmtWrData, mgmtRdData, advWord, v, a;
	logic        linkUpIn, remoteFaultIn, jabberIn, anDoneIn;
	logic        anSpeed100In, anDuplexFullIn, phyResetOut, loopbackEn;
	logic        speed100, duplexFull, anEnable, anRestart, powerDown;
	logic        colTestEn, pauseSymEn, pauseAsymEn;
	logic [1:0]  partnerPauseIn;
	logic [5:0]  e;
	logic [31:0] seed = 32'h0000ee2b;
	logic [31:0] r;
	int          failCount = 0, nTests = 0, k, cnt;

	pbm_regs #(.ID_HIGH_RST(IDH), .ID_LOW_RST(IDL)) dut (
		.clk_sys(clk_sys), .rst_n(rst_n), .mgmtIndex(mgmtIndex),
		.mgmtWrData(mgmtWrData), .mgmtWrite(mgmtWrite),
		.mgmtRead(mgmtRead), .mgmtRdData(mgmtRdData),
		.mgmtRdValid(mgmtRdValid), .linkUpIn(linkUpIn),
		.remoteFaultIn(remoteFaultIn), .jabberIn(jabberIn),
		.anDoneIn(anDoneIn), .anSpeed100In(anSpeed100In),
		.anDuplexFullIn(anDuplexFullIn), .partnerPauseIn(partnerPauseIn),
		.phyResetOut(phyResetOut), .loopbackEn(loopbackEn),
		.speed100(speed100), .duplexFull(duplexFull),
		.anEnable(anEnable), .anRestart(anRestart),
		.powerDown(powerDown), .colTestEn(colTestEn), .advWord(advWord),
		.pauseSymEn(pauseSymEn), .pauseAsymEn(pauseAsymEn));

	pbm_host_model host (
		.clk_sys(clk_sys), .mgmtIndex(mgmtIndex),
		.mgmtWrData(mgmtWrData), .mgmtWrite(mgmtWrite),
		.mgmtRead(mgmtRead), .mgmtRdData(mgmtRdData),
		.mgmtRdValid(mgmtRdValid));

	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// Resolved pause as {asym, sym}; partner is {asym, sym}
	function automatic logic [1:0] pauseExp(input logic [1:0] l, p);
		case (l)
			2'h1: return {1'b0, p[0]};
			2'h2: return {p == 2'h3, 1'b0};
			2'h3: return p[0] ? 2'h1 : {p == 2'h2, 1'b0};
			default: return 2'h0;
		endcase
	endfunction

	task automatic closeOut();
		$display("Checks %0d, mismatches %0d", nTests, failCount);
		if (failCount == 0 && nTests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, exp);
		nTests++;
		if (got !== exp)
		begin
			failCount++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rc(input logic [4:0] i, input logic [15:0] x);
		logic [15:0] d;
		host.rd(i, d);
		if (host.timedOut)
		begin
			failCount++;
			closeOut();
		end
		chk(d, x);
	endtask

	task automatic tick();
		@(posedge clk_sys);
		#1;
	endtask

	task automatic countHigh(ref logic s, output int n);
		n = 0;
		repeat (16)
		begin
			@(negedge clk_sys);
			n += (s === 1'b1);
		end
	endtask

	initial
	begin
		repeat (100000) @(posedge clk_sys);
		failCount++;
		closeOut();
	end

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		rst_n = 1'b0;
		{linkUpIn, remoteFaultIn, jabberIn, anDoneIn} = 4'h8;
		{anSpeed100In, anDuplexFullIn, partnerPauseIn} = 4'h0;
		repeat (16) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		chk({9'h000, speed100, anEnable, loopbackEn, powerDown, colTestEn,
			anRestart, phyResetOut}, 16'h0060);
		chk(advWord, 16'h01e1);
		rc(5'h00, 16'h3000);
		rc(5'h01, 16'h7809);
		rc(5'h01, 16'h780d);
		rc(5'h02, IDH);
		rc(5'h03, IDL);
		for (k = 0; k < 6; k++)
		begin
			r = rnd();
			host.wr(5'h02 + 5'(k[0]), r[15:0]);
			rc(5'h02 + 5'(k[0]), r[15:0]);
			host.wr(5'h05 + r[20:16] % 5'd27, r[31:16]);
			rc(5'h05 + r[20:16] % 5'd27, 16'h0000);
		end
		// Control bits and effective modes
		for (k = 0; k < 14; k++)
		begin
			r = rnd();
			anSpeed100In = r[16];
			anDuplexFullIn = r[17];
			a = (k == 0) ? 16'h3980 : (k == 1) ? 16'h4000 : r[15:0] & 16'h7980;
			host.ctrl(a, v);
			repeat (2) tick();
			e = {v[14], v[12] ? r[16] : v[13], v[12] ? r[17] : v[8], v[12],
				v[11], v[7]};
			chk({10'h000, loopbackEn, speed100, duplexFull, anEnable,
				powerDown, colTestEn}, {10'h000, e});
			rc(5'h00, v);
		end
		host.wr(5'h00, 16'h1200);
		countHigh(anRestart, cnt);
		chk(16'(cnt), 16'h0001);
		rc(5'h00, 16'h1000);
		// Latched status bits
		tick();
		{linkUpIn, remoteFaultIn, jabberIn} = 3'h3;
		rc(5'h01, 16'h781b);
		{linkUpIn, remoteFaultIn, jabberIn} = 3'h4;
		rc(5'h01, 16'h781b);
		rc(5'h01, 16'h780d);
		// Pause codes against every partner code
		for (k = 0; k < 16; k++)
		begin
			r = rnd();
			a = {r[15:12], 2'(k >> 2), r[9:0]} & 16'h2dff;
			host.wr(5'h04, a);
			rc(5'h04, a);
			chk(advWord, a);
			tick();
			partnerPauseIn = 2'(k);
			anDoneIn = 1'b1;
			repeat (3) tick();
			chk({14'h0000, pauseAsymEn, pauseSymEn},
				{14'h0000, pauseExp(2'(k >> 2), 2'(k))});
			rc(5'h01, 16'h782d);
			tick();
			anDoneIn = 1'b0;
		end
		rc(5'h01, 16'h780d);
		// Soft reset from a non-default state
		host.ctrl(16'h4980, v);
		host.softReset();
		countHigh(phyResetOut, cnt);
		chk(16'(cnt), 16'h000a);
		rc(5'h00, 16'h3000);
		rc(5'h02, IDH);
		chk({9'h000, speed100, anEnable, loopbackEn, powerDown, colTestEn,
			anRestart, phyResetOut},
			{9'h000, anSpeed100In, 6'h20});
		chk(advWord, 16'h01e1);
		closeOut();
	end
endmodule // pbm_regs_test
`default_nettype wire
